// ### verilog/adc_post_defines.svh
// register offsets, field positions and reset values of the post-processing chain
// assumes an 8-bit register address space reached over the plain register port
// Operation
// R1: add offset first, then multiply by gain
// R2: correction precedes mixing, filtering and decimation
// R3: global 16-bit offset plus per-channel offsets combined
// R4: two-bit weight scales per-channel offsets
// R5: offset registers map to channels non-sequentially
// R6: eight-bit gain per channel, eight registers
// R7: gain and phase follow channel sequence order
// R8: first control: oscillator, eighth-rate, stage one
// R9: second control: stage two, octal, beamforming
// R10: dual enable bit gates dual-channel processing
// R11: half-band halves rate; decimation doubles
// R12: zero rate code disables its FIR stage
// R13: software programs all-ones for divide 256
// R14: dual real decimation code 0x0e accepted
// R15: software keeps output rate for plain I/Q
// R16: software sets rate 0001 for real output
// R17: software sets rate to total decimation
// R18: up-conversion at eighth rate over extra ratio
// R19: per-channel phase added to shared oscillator
// R20: I and Q summed across all channels
// R21: phase step is full turn over 2^16
// R22: octal beamforming restricts FIR rates
// R23: code zero no shift, ones nearly full turn
// R24: dual outputs ch0 I, ch0 Q, ch1 I, Q
// R25: offset, gain and sums saturate
`ifndef ADC_POST_DEFINES_SVH
`define ADC_POST_DEFINES_SVH
`define OFS_OUT_RATE 8'h02
`define OFS_CHAN_COUNT 8'h03
`define OFS_GLOB_OFS_LO 8'h66
`define OFS_GLOB_OFS_HI 8'h67
`define OFS_DUAL_CTL 8'h79
`define OFS_FIRA_LOW 8'h7a
`define OFS_FIRA_HIGH 8'h7b
`define OFS_FIRB 8'h7c
`define OFS_DDC1_CTL 8'h80
`define OFS_DDC2_CTL 8'h81
`define OFS_PHASE_BASE 8'h86
`define OFS_PHASE_LAST 8'h95
`define OFS_GAIN_BASE 8'h96
`define OFS_GAIN_LAST 8'h9d
`define OFS_COFS_BASE 8'h9e
`define OFS_COFS_LAST 8'ha5
`define OFS_COFS_WEIGHT 8'ha7
`define POS_OSC_EN 5
`define POS_EIGHTH_EN 1
`define POS_DDC1_EN 0
`define POS_DDC2_EN 6
`define POS_OCTAL_EN 3
`define POS_BEAM_EN 2
`define POS_DUAL_EN 7
`define POS_FIRA_LSB 6
`define RST_REG8 8'h00
`define RST_GAIN 8'h80
`define OSC_STEP 16'h2000
`define OCTAL_MAX_CODE 9'h007
`endif

// ### verilog/adc_post_pkg.sv
// types shared by the post-processing chain
// assumes nothing beyond the constants header
package adc_post_pkg;
   typedef logic signed [15:0] word_t;
   typedef struct packed {
      logic valid;
      logic [2:0] pos;
      word_t data;
   } sample_t;
   typedef struct packed {
      logic valid;
      logic slot;
      word_t i;
      word_t q;
   } cplx_t;
endpackage

// ### verilog/adc_post_chain.sv
// offset, gain, mixer, beamform sum, half-band, FIR decimation and up-shift
// assumes samples arrive at most every other clock, pos counting the sequence
`timescale 1ns/10ps
`include "adc_post_defines.svh"
module adc_post_chain (
   // clock and reset
   input wire logic sysClk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // converter samples
   input wire adc_post_pkg::sample_t sampleIn,
   // host capture
   output adc_post_pkg::word_t outData,
   output logic outValid,
   output logic wordMarker
);
   logic [7:0] outRate_r, chanCount_r, dualCtl_r, firALow_r, firAHigh_r, firB_r;
   logic [7:0] ddc1Ctl_r, ddc2Ctl_r, offWeight_r;
   logic [15:0] globOfs_r;
   logic [7:0] gain_r [8];
   logic [7:0] chanOfs_r [8];
   logic [15:0] phase_r [8];
   logic [15:0] rdData_r;

   function automatic adc_post_pkg::word_t sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) return 16'sh7fff;
      if (v < -32'sd32768) return 16'sh8000;
      return v[15:0];
   endfunction

   // coarse eighth-turn table, Q14
   function automatic logic signed [15:0] cosLut(input logic [2:0] idx);
      unique case (idx)
         3'h0: return 16'sh4000;
         3'h1: return 16'sh2d41;
         3'h2: return 16'sh0000;
         3'h3: return -16'sh2d41;
         3'h4: return -16'sh4000;
         3'h5: return -16'sh2d41;
         3'h6: return 16'sh0000;
         3'h7: return 16'sh2d41;
      endcase
   endfunction

   function automatic logic [3:0] log2f(input logic [9:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 1; k < 10; k++) begin
         if (v[k]) r = 4'(k);
      end
      return r;
   endfunction

   // register writes
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         outRate_r <= `RST_REG8;
         chanCount_r <= `RST_REG8;
         dualCtl_r <= `RST_REG8;
         firALow_r <= `RST_REG8;
         firAHigh_r <= `RST_REG8;
         firB_r <= `RST_REG8;
         ddc1Ctl_r <= `RST_REG8;
         ddc2Ctl_r <= `RST_REG8;
         offWeight_r <= `RST_REG8;
         globOfs_r <= 16'h0000;
         for (int k = 0; k < 8; k++) begin
            gain_r[k] <= `RST_GAIN;
            chanOfs_r[k] <= `RST_REG8;
            phase_r[k] <= 16'h0000;
         end
      end else if (regWr) begin
         unique case (regAddr)
            `OFS_OUT_RATE: outRate_r <= regWdata[7:0];
            `OFS_CHAN_COUNT: chanCount_r <= {5'h00, regWdata[2:0]};
            `OFS_GLOB_OFS_LO: globOfs_r[7:0] <= regWdata[7:0];
            `OFS_GLOB_OFS_HI: globOfs_r[15:8] <= regWdata[7:0];
            `OFS_DUAL_CTL: dualCtl_r <= regWdata[7:0];
            `OFS_FIRA_LOW: firALow_r <= regWdata[7:0];
            `OFS_FIRA_HIGH: firAHigh_r <= regWdata[7:0];
            `OFS_FIRB: firB_r <= regWdata[7:0];
            `OFS_DDC1_CTL: ddc1Ctl_r <= regWdata[7:0];
            `OFS_DDC2_CTL: ddc2Ctl_r <= regWdata[7:0];
            `OFS_COFS_WEIGHT: offWeight_r <= {6'h00, regWdata[1:0]}; // R4
            default: begin
               if (regAddr >= `OFS_PHASE_BASE && regAddr <= `OFS_PHASE_LAST) begin
                  if (regAddr[0]) phase_r[3'((regAddr - `OFS_PHASE_BASE) >> 1)][15:8]
                     <= regWdata[7:0];
                  else phase_r[3'((regAddr - `OFS_PHASE_BASE) >> 1)][7:0] <= regWdata[7:0];
               end
               if (regAddr >= `OFS_GAIN_BASE && regAddr <= `OFS_GAIN_LAST)
                  gain_r[3'(regAddr - `OFS_GAIN_BASE)] <= regWdata[7:0]; // R6
               if (regAddr >= `OFS_COFS_BASE && regAddr <= `OFS_COFS_LAST)
                  chanOfs_r[3'(regAddr - `OFS_COFS_BASE)] <= regWdata[7:0];
            end
         endcase
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         rdData_r <= 16'h0000;
      end else if (!regRd) begin
         rdData_r <= 16'h0000;
      end else begin
         unique case (regAddr)
            `OFS_OUT_RATE: rdData_r <= {8'h00, outRate_r};
            `OFS_CHAN_COUNT: rdData_r <= {8'h00, chanCount_r};
            `OFS_GLOB_OFS_LO: rdData_r <= {8'h00, globOfs_r[7:0]};
            `OFS_GLOB_OFS_HI: rdData_r <= {8'h00, globOfs_r[15:8]};
            `OFS_DUAL_CTL: rdData_r <= {8'h00, dualCtl_r};
            `OFS_FIRA_LOW: rdData_r <= {8'h00, firALow_r};
            `OFS_FIRA_HIGH: rdData_r <= {8'h00, firAHigh_r};
            `OFS_FIRB: rdData_r <= {8'h00, firB_r};
            `OFS_DDC1_CTL: rdData_r <= {8'h00, ddc1Ctl_r};
            `OFS_DDC2_CTL: rdData_r <= {8'h00, ddc2Ctl_r};
            `OFS_COFS_WEIGHT: rdData_r <= {8'h00, offWeight_r};
            default: begin
               if (regAddr >= `OFS_PHASE_BASE && regAddr <= `OFS_PHASE_LAST)
                  rdData_r <= regAddr[0] ?
                     {8'h00, phase_r[3'((regAddr - `OFS_PHASE_BASE) >> 1)][15:8]} :
                     {8'h00, phase_r[3'((regAddr - `OFS_PHASE_BASE) >> 1)][7:0]};
               else if (regAddr >= `OFS_GAIN_BASE && regAddr <= `OFS_GAIN_LAST)
                  rdData_r <= {8'h00, gain_r[3'(regAddr - `OFS_GAIN_BASE)]};
               else if (regAddr >= `OFS_COFS_BASE && regAddr <= `OFS_COFS_LAST)
                  rdData_r <= {8'h00, chanOfs_r[3'(regAddr - `OFS_COFS_BASE)]};
               else
                  rdData_r <= 16'h0000;
            end
         endcase
      end
   end
   assign regRdata = rdData_r;

   // mode decode
   logic [2:0] lastPos;
   logic oscEn, eighthEn, ddc1En, ddc2En, beamEn, procEn, realOut;
   logic [8:0] firARate, rateCode;
   logic [9:0] decFactor;
   assign lastPos = chanCount_r[2:0];
   assign oscEn = ddc1Ctl_r[`POS_OSC_EN]; // R8
   assign eighthEn = ddc1Ctl_r[`POS_EIGHTH_EN]; // R8
   assign ddc2En = ddc2Ctl_r[`POS_DDC2_EN]; // R9
   assign beamEn = ddc2Ctl_r[`POS_OCTAL_EN] & ddc2Ctl_r[`POS_BEAM_EN]; // R9
   // dual mode only processes with its own enable set or with octal beamforming on
   assign procEn = (lastPos == 3'h0) | (lastPos == 3'h1 & dualCtl_r[`POS_DUAL_EN]) | beamEn; // R10
   assign ddc1En = ddc1Ctl_r[`POS_DDC1_EN] & procEn; // R8
   assign realOut = eighthEn & ddc2En;
   assign firARate = {firAHigh_r, firALow_r[`POS_FIRA_LSB]};
   // stage A wins when both are set; zero in both leaves the filter out
   always_comb begin
      rateCode = (firARate != 9'h000) ? firARate : {1'b0, firB_r}; // R12 R14
      if (beamEn && rateCode > `OCTAL_MAX_CODE) rateCode = `OCTAL_MAX_CODE; // R22
      if (!procEn) rateCode = 9'h000;
      decFactor = {1'b0, rateCode} + 10'h001;
   end

   // stage 1: offset
   logic [2:0] ofsIdx;
   logic signed [31:0] ofsSum;
   adc_post_pkg::sample_t s1_r, s2_r;
   always_comb begin
      ofsIdx = (lastPos != 3'h7 && sampleIn.pos == 3'h0) ? lastPos + 3'h1 : sampleIn.pos; // R5
      ofsSum = 32'(sampleIn.data) + 32'(signed'(globOfs_r))
             + (32'(signed'(chanOfs_r[ofsIdx])) <<< offWeight_r[1:0]); // R3 R4
   end
   always_ff @(posedge sysClk) begin
      if (!rst_n) s1_r <= '0;
      else s1_r <= '{sampleIn.valid, sampleIn.pos, sat16(ofsSum)}; // R1 R2 R25
   end

   // stage 2: gain, 8'h80 is unity
   logic signed [31:0] gainProd;
   assign gainProd = (32'(s1_r.data) * 32'(signed'({1'b0, gain_r[s1_r.pos]}))) >>> 7; // R7
   always_ff @(posedge sysClk) begin
      if (!rst_n) s2_r <= '0;
      else s2_r <= '{s1_r.valid, s1_r.pos, sat16(gainProd)}; // R1 R6 R25
   end

   // stage 3: mixer; table resolves an eighth turn, finer phase bits are dropped
   logic [15:0] oscAcc_r, mixPhase;
   logic signed [31:0] mixI, mixQ;
   adc_post_pkg::cplx_t s3_r;
   assign mixPhase = (oscEn ? oscAcc_r : 16'h0000) + phase_r[s2_r.pos]; // R19 R21 R23
   assign mixI = (32'(s2_r.data) * 32'(cosLut(mixPhase[15:13]))) >>> 14;
   assign mixQ = (32'(s2_r.data) * 32'(cosLut(mixPhase[15:13] - 3'h2))) >>> 14;
   always_ff @(posedge sysClk) begin
      if (!rst_n) oscAcc_r <= 16'h0000;
      else if (s2_r.valid && s2_r.pos == lastPos && oscEn) oscAcc_r <= oscAcc_r + `OSC_STEP;
   end
   always_ff @(posedge sysClk) begin
      if (!rst_n) s3_r <= '0;
      else if (ddc1En) s3_r <= '{s2_r.valid, s2_r.pos[0], sat16(mixI), sat16(mixQ)};
      else s3_r <= '{s2_r.valid, s2_r.pos[0], s2_r.data, 16'sh0000};
   end

   // stage 4: beamform sum across the sequence
   logic signed [18:0] sumI_r, sumQ_r;
   adc_post_pkg::cplx_t s4_r;
   logic [2:0] s3Pos_r;
   always_ff @(posedge sysClk) begin
      if (!rst_n) s3Pos_r <= 3'h0;
      else s3Pos_r <= s2_r.pos;
   end
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         sumI_r <= '0;
         sumQ_r <= '0;
      end else if (s3_r.valid) begin
         sumI_r <= (s3Pos_r == 3'h0) ? 19'(s3_r.i) : sumI_r + 19'(s3_r.i); // R20
         sumQ_r <= (s3Pos_r == 3'h0) ? 19'(s3_r.q) : sumQ_r + 19'(s3_r.q); // R20
      end
   end
   always_ff @(posedge sysClk) begin
      if (!rst_n) s4_r <= '0;
      else if (beamEn)
         s4_r <= '{s3_r.valid && s3Pos_r == lastPos, 1'b0,
            sat16(32'(s3Pos_r == 3'h0 ? 19'(s3_r.i) : sumI_r + 19'(s3_r.i))),
            sat16(32'(s3Pos_r == 3'h0 ? 19'(s3_r.q) : sumQ_r + 19'(s3_r.q)))}; // R20 R25
      else s4_r <= '{s3_r.valid, (lastPos == 3'h1) & s3_r.slot, s3_r.i, s3_r.q};
   end

   // stage 5: half-band pair average, decimate by two per slot
   logic hbPhase_r [2];
   adc_post_pkg::word_t hbI_r [2], hbQ_r [2];
   adc_post_pkg::cplx_t s5_r;
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         s5_r <= '0;
         for (int k = 0; k < 2; k++) begin
            hbPhase_r[k] <= 1'b0;
            hbI_r[k] <= '0;
            hbQ_r[k] <= '0;
         end
      end else if (!ddc1En) begin
         s5_r <= s4_r;
      end else begin
         s5_r.valid <= s4_r.valid & hbPhase_r[s4_r.slot]; // R11
         s5_r.slot <= s4_r.slot;
         s5_r.i <= 16'((17'(hbI_r[s4_r.slot]) + 17'(s4_r.i)) >>> 1);
         s5_r.q <= 16'((17'(hbQ_r[s4_r.slot]) + 17'(s4_r.q)) >>> 1);
         if (s4_r.valid) begin
            hbPhase_r[s4_r.slot] <= ~hbPhase_r[s4_r.slot];
            hbI_r[s4_r.slot] <= s4_r.i;
            hbQ_r[s4_r.slot] <= s4_r.q;
         end
      end
   end

   // stage 6: FIR decimation by code plus one, integrate and dump
   logic [9:0] decCnt_r [2];
   logic signed [25:0] decI_r [2], decQ_r [2];
   logic signed [25:0] accI, accQ;
   logic [3:0] decShift;
   adc_post_pkg::cplx_t s6_r;
   assign accI = decI_r[s5_r.slot] + 26'(s5_r.i);
   assign accQ = decQ_r[s5_r.slot] + 26'(s5_r.q);
   assign decShift = log2f(decFactor);
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         s6_r <= '0;
         for (int k = 0; k < 2; k++) begin
            decCnt_r[k] <= 10'h000;
            decI_r[k] <= '0;
            decQ_r[k] <= '0;
         end
      end else if (rateCode == 9'h000) begin
         s6_r <= s5_r; // R12
      end else begin
         s6_r.valid <= s5_r.valid && decCnt_r[s5_r.slot] == decFactor - 10'h001;
         s6_r.slot <= s5_r.slot;
         s6_r.i <= sat16(32'(accI >>> decShift));
         s6_r.q <= sat16(32'(accQ >>> decShift));
         if (s5_r.valid) begin
            if (decCnt_r[s5_r.slot] == decFactor - 10'h001) begin
               decCnt_r[s5_r.slot] <= 10'h000;
               decI_r[s5_r.slot] <= '0;
               decQ_r[s5_r.slot] <= '0;
            end else begin
               decCnt_r[s5_r.slot] <= decCnt_r[s5_r.slot] + 10'h001;
               decI_r[s5_r.slot] <= accI;
               decQ_r[s5_r.slot] <= accQ;
            end
         end
      end
   end

   // stage 7: eighth-rate up-shift steps once per decimated output
   logic [2:0] upPh_r [2];
   logic signed [31:0] upReal;
   assign upReal = (32'(s6_r.i) * 32'(cosLut(upPh_r[s6_r.slot]))
                  - 32'(s6_r.q) * 32'(cosLut(upPh_r[s6_r.slot] - 3'h2))) >>> 14;
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         upPh_r[0] <= 3'h0;
         upPh_r[1] <= 3'h0;
      end else if (s6_r.valid && realOut) begin
         upPh_r[s6_r.slot] <= upPh_r[s6_r.slot] + 3'h1; // R18
      end
   end

   // output: complex words go out I then Q, marker on channel 0 I
   logic qPend_r;
   adc_post_pkg::word_t qHold_r;
   always_ff @(posedge sysClk) begin
      if (!rst_n) begin
         outData <= '0;
         outValid <= 1'b0;
         wordMarker <= 1'b0;
         qPend_r <= 1'b0;
         qHold_r <= '0;
      end else if (qPend_r) begin
         outData <= qHold_r; // R24
         outValid <= 1'b1;
         wordMarker <= 1'b0;
         qPend_r <= 1'b0;
      end else begin
         outValid <= s6_r.valid;
         wordMarker <= s6_r.valid && ddc1En && !realOut && !s6_r.slot; // R24
         outData <= realOut ? sat16(upReal) : s6_r.i;
         qPend_r <= s6_r.valid && ddc1En && !realOut; // R24
         qHold_r <= s6_r.q;
      end
   end

   // checks
   chk_offset_first: assert property (@(posedge sysClk) disable iff (!rst_n) // R3
      sampleIn.valid && sampleIn.pos != 3'h0
      |=> s1_r.data == sat16(32'($past(sampleIn.data)) + 32'(signed'($past(globOfs_r)))
      + (32'(signed'($past(chanOfs_r[sampleIn.pos]))) <<< $past(offWeight_r[1:0]))))
      else $error("offset sum wrong");
   chk_gain_after: assert property (@(posedge sysClk) disable iff (!rst_n) // R1
      s1_r.valid && gain_r[s1_r.pos] == `RST_GAIN |=> s2_r.data == $past(s1_r.data))
      else $error("unity gain altered sample");
   chk_first_map: assert property (@(posedge sysClk) disable iff (!rst_n) // R5
      sampleIn.pos == 3'h0 && lastPos == 3'h2 |-> ofsIdx == 3'h3)
      else $error("first channel offset index wrong");
   chk_zero_phase: assert property (@(posedge sysClk) disable iff (!rst_n) // R23
      !oscEn && phase_r[s2_r.pos] == 16'h0000 && ddc1En && s2_r.valid
      |=> s3_r.i == $past(s2_r.data) && s3_r.q == 16'sh0000)
      else $error("zero phase code shifted");
   chk_beam_sum: assert property (@(posedge sysClk) disable iff (!rst_n) // R20
      s3_r.valid && beamEn && s3Pos_r == 3'h0 |=> sumI_r == 19'($past(s3_r.i)))
      else $error("beam sum did not restart");
   chk_hb_halves: assert property (@(posedge sysClk) disable iff (!rst_n) // R11
      ddc1En && s4_r.valid && !hbPhase_r[s4_r.slot] |=> !s5_r.valid)
      else $error("half-band passed both samples");
   chk_fir_off: assert property (@(posedge sysClk) disable iff (!rst_n) // R12
      firARate == 9'h000 && firB_r == 8'h00 |=> s6_r == $past(s5_r))
      else $error("disabled FIR altered stream");
   chk_octal_cap: assert property (@(posedge sysClk) disable iff (!rst_n) // R22
      beamEn |-> decFactor <= 10'h008)
      else $error("octal rate not restricted");
   chk_iq_order: assert property (@(posedge sysClk) disable iff (!rst_n) // R24
      outValid && wordMarker |=> outValid && !wordMarker ##1 !wordMarker)
      else $error("Q did not follow marked I");
   cov_dual_iq: cover property (@(posedge sysClk) disable iff (!rst_n)
      lastPos == 3'h1 && wordMarker ##1 outValid);
   cov_beam_out: cover property (@(posedge sysClk) disable iff (!rst_n)
      beamEn && s4_r.valid);
   cov_real_dec: cover property (@(posedge sysClk) disable iff (!rst_n)
      realOut && rateCode != 9'h000 && s6_r.valid);
endmodule // adc_post_chain

// ### tb/host_capture.sv
// host-side capture model for the processed word stream of the chain
// assumes one word per outValid cycle and no back-pressure on this port
`timescale 1ns/10ps
module host_capture (
   // clock and reset
   input wire logic sysClk,
   input wire logic rst_n,
   // processed words
   input wire adc_post_pkg::word_t outData,
   input wire logic outValid,
   input wire logic wordMarker
);
   adc_post_pkg::word_t got[$];
   int markAt[$];
   int marks = 0;
   int stray = 0;
   // the host latches like a plain register; it cannot stall the chain
   always @(posedge sysClk) begin
      if (rst_n && wordMarker) begin
         marks++;
         markAt.push_back(got.size());
         if (outValid !== 1'b1) begin
            stray++;
         end
      end
      if (rst_n && outValid === 1'b1) begin
         got.push_back(outData);
      end
   end
endmodule // host_capture

// ### tb/test_adc_post_chain.sv
// self-checking bench for the post-processing chain with a behavioural model
// assumes the chain answers within 40 cycles and the host never stalls
`timescale 1ns/10ps
`include "adc_post_defines.svh"
module test_adc_post_chain;
   logic sysClk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata;
   adc_post_pkg::sample_t sampleIn = '0;
   adc_post_pkg::word_t outData;
   logic outValid;
   logic wordMarker;
   int fails = 0;
   int num_checks = 0;
   int seed = 71058;
   int cycles = 0;
   int gain[8];
   int cofs[8];
   int gofs = 0;
   int wt = 0;
   int nch = 1;
   int x;
   int expq[$];
   always #5 sysClk = ~sysClk;
   adc_post_chain adc_post_chain_i (.sysClk(sysClk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .sampleIn(sampleIn), .outData(outData), .outValid(outValid), .wordMarker(wordMarker));
   host_capture host_capture_i (.sysClk(sysClk), .rst_n(rst_n), .outData(outData),
      .outValid(outValid), .wordMarker(wordMarker));
   task check(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge sysClk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("[FAIL] %0t run did not finish in time", $time);
         conclude();
      end
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sysClk);
      regAddr <= a;
      regWdata <= {8'h00, d};
      regWr <= 1'b1;
      @(posedge sysClk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sysClk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sysClk);
      regRd <= 1'b0;
      #1 check(regRdata, exp, "register read");
   endtask
   // the line carries the inverse of the last word while idle so stale data never matches
   task send(input int v, input int p);
      @(posedge sysClk);
      sampleIn <= {1'b1, 3'(p), 16'(v)};
      @(posedge sysClk);
      sampleIn <= {1'b0, 3'(p), ~16'(v)};
   endtask
   task mode(input logic [7:0] c80, c81, c79, fal, fah, fb, cnt);
      wr(`OFS_DDC1_CTL, c80);
      wr(`OFS_DDC2_CTL, c81);
      wr(`OFS_DUAL_CTL, c79);
      wr(`OFS_FIRA_LOW, fal);
      wr(`OFS_FIRA_HIGH, fah);
      wr(`OFS_FIRB, fb);
      wr(`OFS_CHAN_COUNT, cnt);
   endtask
   task corr_regs();
      wr(`OFS_GLOB_OFS_LO, 8'(gofs));
      wr(`OFS_GLOB_OFS_HI, 8'(gofs >>> 8));
      wr(`OFS_COFS_WEIGHT, 8'(wt));
      for (int k = 0; k < 8; k++) begin
         wr(`OFS_GAIN_BASE + 8'(k), 8'(gain[k]));
         wr(`OFS_COFS_BASE + 8'(k), 8'(cofs[k]));
      end
   endtask
   function automatic int sat(input int v);
      return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
   endfunction
   // first sequence slot takes its offset from past the last used channel
   function automatic int corr(input int v, input int p);
      int a;
      a = sat(v + gofs + (cofs[(nch < 8 && p == 0) ? nch : p] <<< wt));
      return sat((a * gain[p]) >>> 7);
   endfunction
   task randomize_corr();
      gofs = $random(seed) % 4096;
      wt = $random(seed) & 3;
      for (int k = 0; k < 8; k++) begin
         gain[k] = $random(seed) & 255;
         cofs[k] = $random(seed) % 128;
      end
   endtask
   task flush(input string name);
      repeat (40) @(posedge sysClk);
      check(16'(host_capture_i.got.size()), 16'(expq.size()), "word count");
      for (int i = 0; i < expq.size() && i < host_capture_i.got.size(); i++) begin
         check(host_capture_i.got[i], 16'(expq[i]), "word value");
      end
      check(16'(host_capture_i.stray), 16'h0000, "marker without word");
      host_capture_i.got.delete();
      host_capture_i.markAt.delete();
      host_capture_i.marks = 0;
      expq.delete();
      $display("test %s done", name);
   endtask
   initial begin
      repeat (4) @(posedge sysClk);
      rst_n <= 1'b1;
      for (int a = 0; a < 176; a++) begin
         rd(8'(a), (a >= 'h96 && a <= 'h9d) ? 16'h0080 : 16'h0000);
      end
      for (int a = 0; a < 176; a++) begin
         x = $random(seed) & 255;
         wr(8'(a), 8'(x));
         if (a == 3 || a == 'ha7) begin
            rd(8'(a), 16'(x & ((a == 3) ? 7 : 3)));
         end else if (a == 2 || a == 'h66 || a == 'h67 || (a >= 'h79 && a <= 'h7c) ||
             a == 'h80 || a == 'h81 || (a >= 'h86 && a <= 'ha5)) begin
            rd(8'(a), 16'(x));
         end else begin
            rd(8'(a), 16'h0000);
         end
      end
      $display("test registers done");
      for (int n = 1; n <= 3; n++) begin
         nch = n;
         repeat (2) begin
            randomize_corr();
            mode(8'h00, 8'h00, (n == 2) ? 8'h80 : 8'h00, 8'h00, 8'h00, 8'h00, 8'(n - 1));
            corr_regs();
            for (int i = 0; i < 12; i++) begin
               x = $random(seed) % 32768;
               send(x, i % n);
               expq.push_back(corr(x, i % n));
            end
            flush("offset and gain");
         end
      end
      nch = 1;
      gofs = 0;
      wt = 0;
      for (int k = 0; k < 8; k++) begin
         gain[k] = 128;
         cofs[k] = 0;
      end
      corr_regs();
      for (int t = 0; t < 4; t++) begin
         static int fal[4] = '{'h40, 'h00, 'h40, 'h00};
         static int fah[4] = '{'h03, 'h00, 'h00, 'h00};
         static int fb[4] = '{'h00, 'h07, 'h00, 'h03};
         static int fac[4] = '{8, 8, 2, 4};
         mode(8'h00, 8'h00, 8'h00, 8'(fal[t]), 8'(fah[t]), 8'(fb[t]), 8'h00);
         wr(`OFS_OUT_RATE, 8'h33);
         x = $random(seed) % 32768;
         for (int i = 0; i < 2 * fac[t]; i++) begin
            send(x, 0);
         end
         expq.push_back(x);
         expq.push_back(x);
         flush("decimation");
      end
      for (int k = 0; k < 16; k++) begin
         wr(`OFS_PHASE_BASE + 8'(k), 8'h00);
      end
      mode(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      x = $random(seed) % 32768;
      for (int i = 0; i < 8; i++) begin
         send(x, 0);
         if (i % 2 == 1) begin
            expq.push_back(x);
            expq.push_back(0);
         end
      end
      repeat (40) @(posedge sysClk);
      check(16'(host_capture_i.marks), 16'h0004, "marker count");
      foreach (host_capture_i.markAt[i]) begin
         check(16'(host_capture_i.markAt[i] % 2), 16'h0000, "marker on I word");
      end
      flush("complex output");
      mode(8'h23, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      wr(`OFS_OUT_RATE, 8'h11);
      for (int i = 0; i < 8; i++) begin
         send(0, 0);
      end
      repeat (4) expq.push_back(0);
      repeat (40) @(posedge sysClk);
      check(16'(host_capture_i.marks), 16'h0000, "marker in real output");
      flush("real output");
      // eight channels at zero phase: each I word is the plain channel sum
      mode(8'h01, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07);
      x = $random(seed) % 4096;
      for (int i = 0; i < 32; i++) begin
         send(x, i % 8);
      end
      repeat (2) begin
         expq.push_back(8 * x);
         expq.push_back(0);
      end
      flush("beamforming");
      conclude();
   end
endmodule // test_adc_post_chain
